// file: src/wcc_ctl.sv
// Purpose: Memory controller end: builds write frames with checksum and watches the alert.
// Assumes: Software loads data, mask and control through a plain register port.
// Notes: Read data appear in the cycle after the read strobe; the port never stalls.
`default_nettype none
// Operation
// - Controller adds 8-bit checksum over code word.
// - Four-bit width: 32 data bits, rest ones.
// - Eight-bit width: 64 data plus mask lane.
// - Sixteen-bit width: two independent checksum trees.
// - Eight/sixteen-bit: transfer 9 all ones.
// - Device recomputes, compares, asserts alert on mismatch.
// - Mask off: write commits, controller rewrites; the controller here only sets the sticky error bit.
// - Mask on: mismatched write is discarded.
// - Checksum over inverted data; invert before storing.
// - Never write inversion together with mask.
// - One-clock preamble: no four-clock command spacing.
// - Two-clock preamble: no six-clock command spacing.
// - No multipurpose register writes, no per-device mode.
// - Polynomial x^8 + x^2 + x + 1.
// - Start at zero; bit 71 shifted first.
// - All eight bits computed in one step.
// - Detects single, double, odd, lane errors.
// - Eight-beat bursts use sequential order from zero.
// - Ten-transfer frame layout with checksum transfers.
// - Chopped writes: A2 picks half sent first.
// - Chopped four-bit: 16 data bits, rest ones.
// - A2 set: upper nibble fills lower inputs.
module wcc_ctl
  import wcc_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Register port.
  input wire logic [7:0] addr_i,
  input wire logic [31:0] wdata_i,
  input wire logic wr_i,
  input wire logic rd_i,
  output logic [31:0] rdata_o,
  // Link.
  wcc_link_if.ctl link
);

  typedef enum {ST_IDLE, ST_SEND, ST_GAP} wcc_ctl_st_t;

  logic [3:0][31:0] data_reg;
  logic [15:0] mask_reg;
  logic [5:0] ctrl_reg;
  logic err_reg;
  logic [15:0] crc_reg;
  logic [9:0][17:0] frame_reg;
  logic [9:0][17:0] frame_next;
  logic [15:0] crc_next;
  logic [143:0] cw;
  logic [3:0] idx_reg;
  logic alert_d_reg;
  logic go;
  logic err_clr;
  wcc_ctl_st_t st_reg;
  wcc_org_t org;
  logic dm_en;
  logic dbi_en;
  logic bc4;
  logic a2;
  logic [5:0] ctrl_use;

  // The control write that starts a frame builds that frame with its own settings, not the stale ones.
  assign ctrl_use = go ? wdata_i[5:0] : ctrl_reg;
  assign org = wcc_org_t'(ctrl_use[WCC_CTRL_ORG +: 2]);
  assign dm_en = ctrl_use[WCC_CTRL_DM];
  // Write inversion is suppressed whenever the mask is on.
  assign dbi_en = ctrl_use[WCC_CTRL_DBI] && !ctrl_use[WCC_CTRL_DM];
  assign bc4 = ctrl_use[WCC_CTRL_BC4];
  assign a2 = ctrl_use[WCC_CTRL_A2];
  assign go = wr_i && (addr_i == WCC_OFS_CTRL) && wdata_i[WCC_CTRL_GO] && (st_reg == ST_IDLE);
  assign err_clr = wr_i && (addr_i == WCC_OFS_STAT) && wdata_i[WCC_STAT_ERR];

  ////////////////////////////////////////////////////////////////////////////
  // Build the data transfers; a chopped write sends only one half, the rest as ones.
  always_comb
  begin
    frame_next = '1;
    for (int t = 0; t < 8; t++)
    begin
      if (!(bc4 && t >= 4))
      begin
        for (int g = 0; g < 2; g++)
        begin
          if (g == 0 || org == ORG_X16)
          begin
            // Sequential order from column zero; A2 picks the upper half for chopped writes.
            frame_next[t][8 * g +: 8] = data_reg[(bc4 && a2 ? t + 4 : t) / 2][16 * ((t % 2)) + 8 * g +: 8]
              ^ {8{dbi_en && mask_reg[2 * (bc4 && a2 ? t + 4 : t) + g]}};
            if (dm_en)
              frame_next[t][16 + g] = !mask_reg[2 * (bc4 && a2 ? t + 4 : t) + g];
            else if (dbi_en)
              frame_next[t][16 + g] = !mask_reg[2 * (bc4 && a2 ? t + 4 : t) + g];
          end
        end
        if (org == ORG_X4)
          frame_next[t][7:4] = 4'hF;
      end
    end
    cw = wcc_code(frame_next, org, bc4, dm_en | dbi_en);
    crc_next = {wcc_crc8(cw[143:72]), wcc_crc8(cw[71:0])};
    // Transfer 8 carries the checksum; transfer 9 carries the high nibble only on the four-bit width.
    if (org == ORG_X4)
    begin
      frame_next[8][3:0] = crc_next[3:0];
      frame_next[9][3:0] = crc_next[7:4];
    end
    else
    begin
      frame_next[8][7:0] = crc_next[7:0];
      if (org == ORG_X16)
        frame_next[8][15:8] = crc_next[15:8];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register writes.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      data_reg <= '0;
      mask_reg <= '0;
      ctrl_reg <= WCC_CTRL_RST;
    end
    else if (wr_i && st_reg == ST_IDLE)
    begin
      if (addr_i >= WCC_OFS_DATA0 && addr_i <= WCC_OFS_DATA3 && addr_i[1:0] == 2'b00)
        data_reg[addr_i[3:2]] <= wdata_i;
      if (addr_i == WCC_OFS_MASK)
        mask_reg <= wdata_i[15:0];
      if (addr_i == WCC_OFS_CTRL)
        ctrl_reg <= wdata_i[5:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame sequencer: send ten transfers, then keep a gap before the next frame.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      st_reg <= ST_IDLE;
      idx_reg <= 4'h0;
      frame_reg <= '1;
      crc_reg <= '0;
    end
    else
    begin
      case (st_reg)
        ST_IDLE:
        begin
          if (go)
          begin
            frame_reg <= frame_next;
            crc_reg <= crc_next;
            idx_reg <= 4'h0;
            st_reg <= ST_SEND;
          end
        end
        ST_SEND:
        begin
          idx_reg <= idx_reg + 4'h1;
          if (idx_reg == WCC_LAST_BEAT)
          begin
            idx_reg <= 4'h0;
            st_reg <= ST_GAP;
          end
        end
        ST_GAP:
        begin
          // Frame starts are never closer than ten plus the gap, so never four or six clocks.
          idx_reg <= idx_reg + 4'h1;
          if (idx_reg == WCC_FRAME_GAP - 4'h1)
            st_reg <= ST_IDLE;
        end
        default:
          st_reg <= ST_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Link outputs from flip-flops; only frame writes are ever issued on this link.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      link.frm_valid <= 1'b0;
      link.frm_first <= 1'b0;
      link.frm_lanes <= '1;
      link.frm_bc4 <= 1'b0;
      link.frm_a2 <= 1'b0;
    end
    else
    begin
      link.frm_valid <= (st_reg == ST_SEND);
      link.frm_first <= (st_reg == ST_SEND) && (idx_reg == 4'h0);
      link.frm_lanes <= (st_reg == ST_SEND) ? frame_reg[idx_reg] : '1;
      link.frm_bc4 <= bc4;
      link.frm_a2 <= a2;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sticky error on alert falling edge; a new alert wins over a clear.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      alert_d_reg <= 1'b1;
      err_reg <= 1'b0;
    end
    else
    begin
      alert_d_reg <= link.alert_n;
      if (alert_d_reg && !link.alert_n)
        err_reg <= 1'b1;
      else if (err_clr)
        err_reg <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Register reads, answered the cycle after the strobe; unmapped reads give zero.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rdata_o <= '0;
    else if (rd_i)
    begin
      rdata_o <= '0;
      if (addr_i >= WCC_OFS_DATA0 && addr_i <= WCC_OFS_DATA3 && addr_i[1:0] == 2'b00)
        rdata_o <= data_reg[addr_i[3:2]];
      else if (addr_i == WCC_OFS_MASK)
        rdata_o <= {16'h0000, mask_reg};
      else if (addr_i == WCC_OFS_CTRL)
        rdata_o <= {26'h0000000, ctrl_reg};
      else if (addr_i == WCC_OFS_STAT)
        rdata_o <= {8'h00, crc_reg, 6'h00, err_reg, st_reg != ST_IDLE};
    end
  end

endmodule
`default_nettype wire

// file: src/wcc_dev.sv
// Purpose: Memory device end: receives write frames, rechecks the checksum, commits to the array.
// Assumes: The controller keeps the frame layout; mode inputs are static during a frame.
// Notes: A frame is always ten transfers; with checksum disabled the check is skipped.
`default_nettype none
module wcc_dev
  import wcc_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Mode settings.
  input wire wcc_org_t org_i,
  input wire logic crc_en_i,
  input wire logic dm_en_i,
  input wire logic dbi_en_i,
  // Link.
  wcc_link_if.dev link,
  // Array write port.
  output logic arr_we_o,
  output logic [127:0] arr_data_o,
  output logic [15:0] arr_be_o,
  output logic crc_err_o
);

  logic [9:0][17:0] beat_reg;
  logic [3:0] idx_reg;
  logic bc4_reg;
  logic a2_reg;
  logic done_reg;
  logic [143:0] cw;
  logic [15:0] calc_crc;
  logic [15:0] rx_crc;
  logic mismatch;
  logic [127:0] wdata;
  logic [15:0] wbe;
  logic [3:0] alert_cnt_reg;

  ////////////////////////////////////////////////////////////////////////////
  // Capture the ten transfers of a frame; done_reg pulses after transfer 9.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      beat_reg <= '1;
      idx_reg <= 4'h0;
      bc4_reg <= 1'b0;
      a2_reg <= 1'b0;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= 1'b0;
      if (link.frm_valid)
      begin
        if (link.frm_first)
        begin
          beat_reg[0] <= link.frm_lanes;
          idx_reg <= 4'h1;
          bc4_reg <= link.frm_bc4;
          a2_reg <= link.frm_a2;
        end
        else
        begin
          beat_reg[idx_reg] <= link.frm_lanes;
          idx_reg <= idx_reg + 4'h1;
          done_reg <= (idx_reg == WCC_LAST_BEAT);
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Recompute both checksum trees over the frame exactly as received.
  always_comb
  begin
    cw = wcc_code(beat_reg, org_i, bc4_reg, dm_en_i | dbi_en_i);
    calc_crc = {wcc_crc8(cw[143:72]), wcc_crc8(cw[71:0])};
    rx_crc = wcc_rx_crc(beat_reg, org_i);
    mismatch = (calc_crc[7:0] != rx_crc[7:0]) ||
               ((org_i == ORG_X16) && (calc_crc[15:8] != rx_crc[15:8]));
  end

  ////////////////////////////////////////////////////////////////////////////
  // Map received transfers to burst positions, undo inversion and apply masks.
  always_comb
  begin
    wdata = '0;
    wbe = '0;
    for (int t = 0; t < 8; t++)
    begin
      if (!(bc4_reg && t >= 4))
      begin
        for (int g = 0; g < 2; g++)
        begin
          // A chopped write with A2 set lands in the upper half of the burst.
          if (bc4_reg && a2_reg)
          begin
            wdata[16 * (t + 4) + 8 * g +: 8] = beat_reg[t][8 * g +: 8] ^
              {8{dbi_en_i && !dm_en_i && !beat_reg[t][16 + g]}};
            wbe[2 * (t + 4) + g] = (g == 0 || org_i == ORG_X16) && !(dm_en_i && !beat_reg[t][16 + g]);
          end
          else
          begin
            wdata[16 * t + 8 * g +: 8] = beat_reg[t][8 * g +: 8] ^
              {8{dbi_en_i && !dm_en_i && !beat_reg[t][16 + g]}};
            wbe[2 * t + g] = (g == 0 || org_i == ORG_X16) && !(dm_en_i && !beat_reg[t][16 + g]);
          end
        end
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Commit the write; with mask on a bad checksum discards it, otherwise it is written anyway.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      arr_we_o <= 1'b0;
      arr_data_o <= '0;
      arr_be_o <= '0;
      crc_err_o <= 1'b0;
    end
    else
    begin
      arr_we_o <= done_reg && !(crc_en_i && dm_en_i && mismatch);
      crc_err_o <= done_reg && crc_en_i && mismatch;
      if (done_reg)
      begin
        arr_data_o <= wdata;
        arr_be_o <= wbe;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Hold the alert low for a fixed number of cycles after a mismatch.
  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      alert_cnt_reg <= 4'h0;
    else if (done_reg && crc_en_i && mismatch)
      alert_cnt_reg <= 4'(WCC_ALERT_CYC);
    else if (alert_cnt_reg != 4'h0)
      alert_cnt_reg <= alert_cnt_reg - 4'h1;
  end

  assign link.alert_n = (alert_cnt_reg == 4'h0);

endmodule
`default_nettype wire

// file: src/wcc_link_if.sv
// Purpose: Write frame link between the memory controller and the memory device.
// Assumes: One transfer per mclk while frm_valid is high; frm_first marks transfer 0.
// Notes: Mode settings (width, mask, inversion) are programmed alike at both ends; only the device end has a checksum enable.
`default_nettype none
interface wcc_link_if;
  logic frm_valid;
  logic frm_first;
  logic [17:0] frm_lanes;
  logic frm_bc4;
  logic frm_a2;
  logic alert_n;

  // Controller end drives the frame and watches the alert.
  modport ctl (output frm_valid, output frm_first, output frm_lanes, output frm_bc4, output frm_a2,
               input alert_n);
  // Device end receives the frame and drives the alert.
  modport dev (input frm_valid, input frm_first, input frm_lanes, input frm_bc4, input frm_a2,
               output alert_n);
endinterface
`default_nettype wire

// file: src/wcc_pkg.sv
// Purpose: Shared constants, types and checksum functions for the write-data checksum link.
// Assumes: One frame transfer per clock; lane 16 and 17 are the lower and upper mask/inversion lanes.
// Notes: The code word layout and checksum are used identically by both ends.
`default_nettype none
package wcc_pkg;

  // Organisation of the memory device.
  typedef enum logic [1:0] {ORG_X4, ORG_X8, ORG_X16} wcc_org_t;

  // Frame geometry.
  localparam int WCC_BEATS = 10;
  localparam int WCC_LANES = 18;
  localparam int WCC_CW_BITS = 72;
  localparam logic [7:0] WCC_POLY = 8'h07;
  localparam logic [7:0] WCC_CRC_INIT = 8'h00;
  localparam logic [3:0] WCC_LAST_BEAT = 4'h9;

  // Alert pulse length and least idle gap between controller frames, in clock cycles.
  localparam int WCC_ALERT_CYC = 6;
  localparam logic [3:0] WCC_FRAME_GAP = 4'h2;

  // Controller register byte offsets.
  localparam logic [7:0] WCC_OFS_DATA0 = 8'h00;
  localparam logic [7:0] WCC_OFS_DATA3 = 8'h0C;
  localparam logic [7:0] WCC_OFS_MASK = 8'h10;
  localparam logic [7:0] WCC_OFS_CTRL = 8'h14;
  localparam logic [7:0] WCC_OFS_STAT = 8'h18;

  // Control register fields and reset value.
  localparam int WCC_CTRL_ORG = 0;
  localparam int WCC_CTRL_DM = 2;
  localparam int WCC_CTRL_DBI = 3;
  localparam int WCC_CTRL_BC4 = 4;
  localparam int WCC_CTRL_A2 = 5;
  localparam int WCC_CTRL_GO = 6;
  localparam logic [5:0] WCC_CTRL_RST = 6'h00;

  // Status register fields.
  localparam int WCC_STAT_BUSY = 0;
  localparam int WCC_STAT_ERR = 1;
  localparam int WCC_STAT_CRC = 8;

  // Serial checksum x^8+x^2+x+1 from zero, highest bit shifted in first, unrolled in one step.
  function automatic logic [7:0] wcc_crc8(input logic [71:0] d);
    logic [7:0] c;
    logic fb;
    c = WCC_CRC_INIT;
    for (int i = WCC_CW_BITS - 1; i >= 0; i--)
    begin
      fb = c[7] ^ d[i];
      c = {c[6:0], 1'b0} ^ (fb ? WCC_POLY : 8'h00);
    end
    return c;
  endfunction

  // Build the 144-bit code word (two 72-bit halves) from the received or sent frame.
  function automatic logic [143:0] wcc_code(input logic [9:0][17:0] bt, input wcc_org_t org,
                                            input logic bc4, input logic dmi_used);
    logic [143:0] cw;
    cw = '1;
    for (int t = 0; t < 8; t++)
    begin
      if (!(bc4 && t >= 4))
      begin
        for (int l = 0; l < 8; l++)
        begin
          if (org != ORG_X4 || l < 4)
            cw[8 * l + t] = bt[t][l];
          if (org == ORG_X16)
            cw[72 + 8 * l + t] = bt[t][8 + l];
        end
        if (org != ORG_X4 && dmi_used)
          cw[64 + t] = bt[t][16];
        if (org == ORG_X16 && dmi_used)
          cw[136 + t] = bt[t][17];
      end
    end
    return cw;
  endfunction

  // Checksum bits carried in transfers 8 and 9: lower byte group low, upper group high.
  function automatic logic [15:0] wcc_rx_crc(input logic [9:0][17:0] bt, input wcc_org_t org);
    logic [15:0] c;
    c[15:8] = bt[8][15:8];
    c[7:0] = (org == ORG_X4) ? {bt[9][3:0], bt[8][3:0]} : bt[8][7:0];
    return c;
  endfunction

endpackage
`default_nettype wire

// file: tb/tb.sv
// Purpose: Self-checking bench for the controller and device ends of the checksum link.
// Assumes: Controller registers reached over the plain strobe port, device modes driven here.
// Notes: Expected checksums come from a serial model kept in this file.
`default_nettype none
module tb
  import wcc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic mclk_i = 1'b0, rst_n_i = 1'b0, wr_i = 1'b0, rd_i = 1'b0;
  logic [7:0] addr_i = 8'h00;
  logic [31:0] wdata_i = 32'h0, rdata_o;
  wcc_org_t org_i = ORG_X8;
  logic crc_en_i = 1'b1, dm_en_i = 1'b0, dbi_en_i = 1'b0, arr_we_o, crc_err_o;
  logic [127:0] arr_data_o, arr_d;
  logic [15:0] arr_be_o, arr_b;
  logic [17:0] fr [16];
  int bi = 0, we_cnt = 0, er_cnt = 0, al_cnt = 0, fails = 0, cmp_count = 0, runs = 0;
  logic [31:0] st;

  ////////////////////////////////////////////////////////////////////////////
  // Clock, link and the two ends.
  always #12.5 mclk_i = ~mclk_i;
  wcc_link_if link();
  wcc_ctl u_wcc_ctl (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .addr_i(addr_i), .wdata_i(wdata_i),
    .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o), .link(link));
  wcc_dev u_wcc_dev (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .org_i(org_i), .crc_en_i(crc_en_i),
    .dm_en_i(dm_en_i), .dbi_en_i(dbi_en_i), .link(link), .arr_we_o(arr_we_o),
    .arr_data_o(arr_data_o), .arr_be_o(arr_be_o), .crc_err_o(crc_err_o));
  wcc_link_chk u_wcc_link_chk (.mclk_i(mclk_i), .rst_n_i(rst_n_i), .frm_valid(link.frm_valid),
    .frm_first(link.frm_first), .frm_lanes(link.frm_lanes), .frm_bc4(link.frm_bc4),
    .frm_a2(link.frm_a2), .alert_n(link.alert_n), .org_i(org_i));

  // Captures each frame and counts commits, errors and alert cycles.
  always @(posedge mclk_i)
  begin
    if (link.frm_valid === 1'b1)
    begin
      if (link.frm_first === 1'b1)
        bi = 0;
      fr[bi % 16] = link.frm_lanes;
      bi = bi + 1;
    end
    if (arr_we_o === 1'b1)
    begin
      we_cnt++;
      arr_d = arr_data_o;
      arr_b = arr_be_o;
    end
    if (crc_err_o === 1'b1)
      er_cnt++;
    if (link.alert_n === 1'b0)
      al_cnt++;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Serial checksum from zero, top bit first.
  function automatic logic [7:0] ref_crc(input logic [71:0] d);
    logic [7:0] c;
    c = 8'h00;
    for (int i = 71; i >= 0; i--)
      c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
    return c;
  endfunction

  // Checksums of the captured frame as an end with the given settings sees it.
  function automatic logic [15:0] ref_sum(input wcc_org_t o, input logic dmi, input logic bc4);
    logic [71:0] lo, hi;
    lo = '1;
    hi = '1;
    for (int t = 0; t < 8; t++)
      for (int l = 0; l < 9; l++)
        if (!(bc4 && t > 3) && (o != ORG_X4 || l < 4) && (l < 8 || (dmi && o != ORG_X4)))
        begin
          lo[8 * l + t] = fr[t][l == 8 ? 16 : l];
          hi[8 * l + t] = (o == ORG_X16) ? fr[t][l == 8 ? 17 : l + 8] : 1'b1;
        end
    return {ref_crc(hi), ref_crc(lo)};
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // Register port cycles, compare and closing report.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    wdata_i <= d;
    wr_i <= 1'b1;
    @(posedge mclk_i);
    wr_i <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge mclk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge mclk_i);
    rd_i <= 1'b0;
    #1;
    d = rdata_o;
  endtask

  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, got);
    end
  endtask

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  // Sends one frame with control bits ctl and checks wire, alert, status and array.
  task automatic run(input logic [6:0] ctl, input logic [15:0] msk, input wcc_org_t dorg,
                     input logic ddm, input logic ddbi);
    logic [127:0] dat;
    logic [15:0] s, r, m, e;
    logic bad, inv;
    logic [15:0] lm;
    logic [31:0] dm32;
    wcc_org_t o;
    int n, src;
    o = wcc_org_t'(ctl[1:0]);
    inv = ctl[3] && !ctl[2];
    runs++;
    dat = {32'h0F1E_2D3C, 32'h4B5A_6978, 32'h8796_A5B4, 32'hC3D2_E1F0} ^ {4{32'(runs * 32'h0301_0701)}};
    @(posedge mclk_i);
    org_i <= dorg;
    dm_en_i <= ddm;
    dbi_en_i <= ddbi;
    for (int i = 0; i < 4; i++)
      wr(8'(4 * i), dat[32 * i +: 32]);
    wr(WCC_OFS_MASK, {16'h0000, msk});
    we_cnt = 0;
    er_cnt = 0;
    al_cnt = 0;
    wr(WCC_OFS_CTRL, {25'h0, ctl});
    repeat (2) @(posedge mclk_i);
    for (n = 0; n < 40; n++)
    begin
      rd(WCC_OFS_STAT, st);
      if (st[WCC_STAT_BUSY] === 1'b0)
        break;
    end
    if (n == 40)
    begin
      fails++;
      test_done();
    end
    repeat (12) @(posedge mclk_i);
    m = (o == ORG_X16) ? 16'hFFFF : 16'h00FF;
    lm = m & ((o == ORG_X4) ? 16'h000F : 16'hFFFF);
    s = ref_sum(o, ctl[2] || ctl[3], ctl[4]);
    r = {fr[8][15:8], o == ORG_X4 ? {fr[9][3:0], fr[8][3:0]} : fr[8][7:0]};
    chk("sent checksum", {16'h0, s & m}, {16'h0, r & m});
    chk("status checksum", {16'h0, s & m}, {16'h0, st[23:8] & m});
    for (int t = 0; t < 8; t++)
    begin
      src = (ctl[4] && ctl[5] && t < 4) ? t + 4 : t;
      e = dat[16 * src +: 16] ^ (inv ? {{8{msk[2 * src + 1]}}, {8{msk[2 * src]}}} : 16'h0000);
      e = (ctl[4] && t > 3) ? 16'hFFFF : e;
      chk("wire beat", {16'h0, e & lm}, {16'h0, fr[t][15:0] & lm});
    end
    s = ref_sum(dorg, ddm || ddbi, ctl[4]);
    r = {fr[8][15:8], dorg == ORG_X4 ? {fr[9][3:0], fr[8][3:0]} : fr[8][7:0]};
    bad = (dorg == ORG_X16) ? (s != r) : (s[7:0] != r[7:0]);
    chk("checksum errors", {31'h0, bad}, er_cnt);
    chk("alert cycles", bad ? WCC_ALERT_CYC : 0, al_cnt);
    chk("array writes", (bad && ddm) ? 0 : 1, we_cnt);
    rd(WCC_OFS_STAT, st);
    chk("status error", {31'h0, bad}, {31'h0, st[WCC_STAT_ERR]});
    wr(WCC_OFS_STAT, 32'h0000_0002);
    rd(WCC_OFS_STAT, st);
    chk("status error cleared", 32'h0, {31'h0, st[WCC_STAT_ERR]});
    if (dorg == o && !ctl[4] && o != ORG_X4 && we_cnt == 1)
    begin
      dm32 = (o == ORG_X16) ? 32'hFFFF_FFFF : 32'h00FF_00FF;
      for (int i = 0; i < 4; i++)
        if (!ctl[2])
          chk("array data", dat[32 * i +: 32] & dm32, arr_d[32 * i +: 32] & dm32);
      e = (ctl[2] ? ~msk : 16'hFFFF) & (o == ORG_X16 ? 16'hFFFF : 16'h5555);
      chk("byte enables", {16'h0, e}, {16'h0, arr_b});
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // Main sequence: reset, register checks, then one frame per mode.
  initial
  begin
    repeat (16) @(posedge mclk_i);
    rst_n_i <= 1'b1;
    rd(WCC_OFS_STAT, st);
    chk("status after reset", 32'h0, st);
    rd(WCC_OFS_CTRL, st);
    chk("control after reset", 32'h0, st);
    rd(8'h1C, st);
    chk("unmapped read", 32'h0, st);
    run(7'h41, 16'h0000, ORG_X8, 1'b0, 1'b0);
    run(7'h42, 16'h0000, ORG_X16, 1'b0, 1'b0);
    run(7'h40, 16'h0000, ORG_X4, 1'b0, 1'b0);
    run(7'h50, 16'h0000, ORG_X4, 1'b0, 1'b0);
    run(7'h70, 16'h0000, ORG_X4, 1'b0, 1'b0);
    run(7'h71, 16'h0000, ORG_X8, 1'b0, 1'b0);
    run(7'h4A, 16'hA5C3, ORG_X16, 1'b0, 1'b1);
    run(7'h46, 16'h3C18, ORG_X16, 1'b1, 1'b0);
    run(7'h4F, 16'hF00F, ORG_X16, 1'b1, 1'b0);
    run(7'h45, 16'h0F0F, ORG_X4, 1'b0, 1'b0);
    run(7'h41, 16'h0000, ORG_X4, 1'b1, 1'b0);
    run(7'h41, 16'h0000, ORG_X16, 1'b0, 1'b0);
    test_done();
  end

  // Cuts a hung run short.
  initial
  begin
    repeat (20000) @(posedge mclk_i);
    fails++;
    test_done();
  end
endmodule
`default_nettype wire

// file: tb/wcc_link_chk.sv
// Purpose: Concurrent checks on the write frame link between controller and device.
// Assumes: One clock domain; org_i is the organisation the device end is set to.
// Notes: Instantiated beside the link interface in the bench top, no bind.
`default_nettype none
module wcc_link_chk
  import wcc_pkg::*;
(
  // Clock and reset.
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // Link signals.
  input wire logic frm_valid,
  input wire logic frm_first,
  input wire logic [17:0] frm_lanes,
  input wire logic frm_bc4,
  input wire logic frm_a2,
  input wire logic alert_n,
  // Device mode.
  input wire wcc_org_t org_i
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);

  ////////////////////////////////////////////////////////////////////////////
  // Counts the transfers of the frame under way; the first idle cycle still shows the full count.
  logic [3:0] vld_run_reg;

  always_ff @(posedge mclk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      vld_run_reg <= 4'h0;
    else if (frm_valid)
      vld_run_reg <= vld_run_reg + 4'h1;
    else
      vld_run_reg <= 4'h0;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Named steps of a chopped frame and of an alert.
  sequence s_chop_ones;
    (&frm_lanes[3:0]) [*4];
  endsequence
  sequence s_alert_pulse;
    !alert_n [*6] ##1 alert_n;
  endsequence

  ////////////////////////////////////////////////////////////////////////////
  // Frame shape: ten transfers, first marked, idle gap after.
  a_frame_ten_beats: assert property (frm_valid ? vld_run_reg < 4'hA : vld_run_reg inside {4'h0, 4'hA})
    else $error("frame length is not ten transfers");
  a_first_opens: assert property ($rose(frm_valid) |-> frm_first ##1 (frm_valid && !frm_first))
    else $error("frame start marker misplaced");
  a_first_in_frame: assert property (frm_first |-> frm_valid)
    else $error("start marker outside a frame");
  a_frame_gap: assert property ($fell(frm_valid) |-> !frm_valid [*2])
    else $error("idle gap between frames too short");
  // Checksum transfers on the byte-wide organisations.
  a_last_beat_ones: assert property (frm_first && org_i != ORG_X4 |->
    ##8 frm_lanes[16] ##1 (frm_lanes[16] && &frm_lanes[7:0]))
    else $error("mask lane or final transfer not all ones");
  // Chopped bursts fill the second half with ones and hold their mode.
  a_chop_fill: assert property (frm_first && frm_bc4 |-> ##4 s_chop_ones)
    else $error("chopped frame second half not ones");
  a_chop_mode_held: assert property (frm_valid && !frm_first |-> $stable(frm_bc4) && $stable(frm_a2))
    else $error("chop mode changed inside a frame");
  // Alert is a fixed pulse that follows the end of a frame.
  a_alert_width: assert property ($fell(alert_n) |-> s_alert_pulse)
    else $error("alert pulse length wrong");
  a_alert_cause: assert property ($fell(alert_n) |-> ($past(frm_valid, 2) || $past(frm_valid, 3)))
    else $error("alert not tied to a frame end");
endmodule
`default_nettype wire
